// ---- sbmc_pkg.sv ----
/*
 * Constants for the secondary bus miscellaneous control block:
 * register offsets, field positions, reset values and timer counts.
 * Assumes a 25 MHz APB clock; all counts are derived from that rate.
 */
package sbmc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] MISC_OFFSET       = 12'h044;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h060;
  localparam logic [11:0] IRQ_MASK_OFFSET   = 12'h064;
  localparam logic [31:0] MISC_RESET        = 32'h7D10_1900;
  localparam logic [31:0] MISC_WRITE_MASK   = 32'h7C9F_7F00;

  // ****************************************************************
  // Field positions of the control register
  // ****************************************************************
  localparam int INT_ARB_EN_BIT  = 30;
  localparam int REQ_ARB_EN_LSB  = 26;
  localparam int PERR_DISCARD_BIT = 24;
  localparam int SHORT_TERM_CACHE_ENABLE_BIT      = 23;
  localparam int INT_HIGH_PRI_BIT = 20;
  localparam int REQ_HIGH_PRI_LSB = 16;
  localparam int ACC_LSB         = 11;
  localparam int RT_LSB          = 8;

  // ****************************************************************
  // Interrupt status layout
  // ****************************************************************
  localparam int IRQ_W         = 3;
  localparam int IRQ_PERR      = 0;
  localparam int IRQ_CFG_RETRY = 1;
  localparam int IRQ_ACC_DONE  = 2;

  // ****************************************************************
  // Completion accumulation
  // ****************************************************************
  localparam logic [6:0] ACC_UNIT_DW  = 7'h08;
  localparam logic [3:0] ACC_MAX_CODE = 4'h9;

  // ****************************************************************
  // Configuration retry timer
  // ****************************************************************
  localparam int CLK_MHZ      = 25;
  localparam int RT0_US       = 25;
  localparam int RT1_US       = 40;
  localparam int RT2_US       = 50;
  localparam int RT3_US       = 100;
  localparam int RT4_US       = 200;
  localparam int RT6_MS       = 1;
  localparam int RT7_MS       = 10;
  localparam int RT0_CYCLES   = RT0_US * CLK_MHZ;
  localparam int RT1_CYCLES   = RT1_US * CLK_MHZ;
  localparam int RT2_CYCLES   = RT2_US * CLK_MHZ;
  localparam int RT3_CYCLES   = RT3_US * CLK_MHZ;
  localparam int RT4_CYCLES   = RT4_US * CLK_MHZ;
  localparam int RT6_CYCLES   = RT6_MS * 1000 * CLK_MHZ;
  localparam int RT7_CYCLES   = RT7_MS * 1000 * CLK_MHZ;
  localparam int RT_CNT_W     = 18;

  // ****************************************************************
  // Arbiter states
  // ****************************************************************
  typedef enum logic {
    SBMC_ARB_IDLE,
    SBMC_ARB_BUSY
  } sbmc_arb_state_t;

endpackage : sbmc_pkg

// ---- sbmc_top.sv ----
/*
 * Secondary bus miscellaneous control: one control register on APB
 * that steers the secondary bus arbiter, parity error handling of
 * non-posted writes, completion accumulation and the config retry timer.
 * Assumes request pins are asynchronous and active low; all other event
 * inputs but the internal_request level are single-cycle pulses from logic on pclk.
 * The surrounding bridge owns the buses themselves: this block only
 * hands out grants, flags parity errors and times completions.
 * Long retry timer settings are parameters so a bench can shorten them.
 * Unmapped APB addresses answer with pslverr and ignore writes.
 * Status and mask registers sit beside the control word at fixed offsets.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - Bit 30 gates internal requests into arbitration
// - Bits 29-26 enable external request lines 3-0
// - Bit 20 puts internal requests high group
// - Bits 19-16 put lines 3-0 high group
// - Bit24 clear: flag parity error, forward data
// - Bit24 set: flag, terminate, set status, discard
// - Parity behaviour bit read-only, resets to one
// - Bit 23 enables short-term caching, reset zero
// - Threshold is eight dwords times code plus one
// - Collect threshold data before returning completion data
// - Retry timer expiry returns retry-status completion
// - Timer codes select 25us up to 10ms
module sbmc_top #(
  parameter int RT4_CYCLES = sbmc_pkg::RT4_CYCLES,
  parameter int RT6_CYCLES = sbmc_pkg::RT6_CYCLES,
  parameter int RT7_CYCLES = sbmc_pkg::RT7_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [3:0]  secondary_request_line_n,
  input  wire logic        internal_request,
  output logic [3:0]       secondary_grant_line_n,
  output logic             internal_grant_n,
  input  wire logic        np_write_parity_error,
  output logic             parity_error_out_n,
  output logic             np_write_forward,
  output logic             np_write_discard,
  output logic             short_term_cache_enable,
  input  wire logic        cpl_start,
  input  wire logic        cpl_dword,
  input  wire logic        cpl_last,
  output logic             cpl_release,
  input  wire logic        cfg1_start,
  input  wire logic        cfg1_done,
  output logic             cfg_retry_status
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    // Register file and APB answer
    logic [31:0]               misc;
    logic [sbmc_pkg::IRQ_W-1:0] irq_status;
    logic [sbmc_pkg::IRQ_W-1:0] irq_mask;
    logic                      irq;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    // Request synchroniser and arbiter
    logic [3:0]                req_meta;
    logic [3:0]                req_sync;
    sbmc_pkg::sbmc_arb_state_t arb;
    logic [4:0]                grant_n;
    logic [2:0]                last;
    // Parity error outputs
    logic                      perr_n;
    logic                      np_forward;
    logic                      np_discard;
    // Completion accumulation
    logic                      acc_active;
    logic [6:0]                acc_count;
    logic                      acc_release;
    // Retry timer
    logic                      rt_active;
    logic [sbmc_pkg::RT_CNT_W-1:0] rt_count;
    logic                      rt_crs;
  } sbmc_state_t;

  // Current and next copy of the whole state
  sbmc_state_t s_q;
  sbmc_state_t s_d;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Round-robin search, starting just after the last winner
  // Index 4 is the internal requester; the pointer is shared by both groups
  // An empty mask leaves the pick at the old winner, which the caller ignores
  function automatic logic [2:0] sbmc_rr_pick(input logic [4:0] mask,
                                              input logic [2:0] last);
    logic [2:0] pick;
    logic       found;
    int         idx;
    pick  = last;
    found = 1'b0;
    for (int i = 1; i <= 5; i++) begin
      idx = (int'(last) + i) % 5;
      if (!found && mask[idx]) begin
        pick  = 3'(idx);
        found = 1'b1;
      end
    end
    return pick;
  endfunction : sbmc_rr_pick

  // Timer code to cycle count; code 101 takes the 1 ms setting
  // Counts are one less than the span because expiry takes one more edge
  function automatic logic [sbmc_pkg::RT_CNT_W-1:0] sbmc_rt_limit(input logic [2:0] code);
    int cyc;
    case (code)
      3'h0:    cyc = sbmc_pkg::RT0_CYCLES;
      3'h1:    cyc = sbmc_pkg::RT1_CYCLES;
      3'h2:    cyc = sbmc_pkg::RT2_CYCLES;
      3'h3:    cyc = sbmc_pkg::RT3_CYCLES;
      3'h4:    cyc = RT4_CYCLES;
      3'h5:    cyc = RT6_CYCLES;
      3'h6:    cyc = RT6_CYCLES;
      default: cyc = RT7_CYCLES;
    endcase
    return sbmc_pkg::RT_CNT_W'(cyc - 1);
  endfunction : sbmc_rt_limit

  // ****************************************************************
  // Decoded controls
  // ****************************************************************
  logic [4:0] arb_enable;
  logic [4:0] arb_high;
  logic       perr_discard;
  logic [3:0] acc_code;
  logic [6:0] acc_threshold;

  // Internal requester sits at index 4 beside lines 3..0
  // Codes above the top of the table saturate rather than wrap, so a
  // stray write can only lengthen the wait, never shorten it
  always_comb begin
    arb_enable    = {s_q.misc[sbmc_pkg::INT_ARB_EN_BIT],
                     s_q.misc[sbmc_pkg::REQ_ARB_EN_LSB +: 4]};
    arb_high      = {s_q.misc[sbmc_pkg::INT_HIGH_PRI_BIT],
                     s_q.misc[sbmc_pkg::REQ_HIGH_PRI_LSB +: 4]};
    perr_discard  = s_q.misc[sbmc_pkg::PERR_DISCARD_BIT];
    acc_code      = s_q.misc[sbmc_pkg::ACC_LSB +: 4];
    if (acc_code > sbmc_pkg::ACC_MAX_CODE) begin
      acc_code = sbmc_pkg::ACC_MAX_CODE;
    end
    acc_threshold = 7'(sbmc_pkg::ACC_UNIT_DW * (7'(acc_code) + 7'h01));
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic [4:0] eligible;
  logic [4:0] high_req;
  logic [4:0] pool;
  logic [2:0] win;
  logic       setup;
  localparam int IRQ_EVT_W = sbmc_pkg::IRQ_W;

  // Scratch values of the next-state process
  logic       wr_acc;
  logic [IRQ_EVT_W-1:0] irq_set;

  always_comb begin
    s_d = s_q;

    // Request pins: first flop feeds only the second
    // Nothing else reads req_meta, so metastability cannot spread
    s_d.req_meta = secondary_request_line_n;
    s_d.req_sync = s_q.req_meta;

    // Register access; answer is ready one cycle after setup
    // Read data is latched at setup so it stands through the access phase
    setup  = psel && !penable;
    wr_acc = psel && penable && pwrite && s_q.pready;
    s_d.pready  = setup;
    s_d.pslverr = 1'b0;
    if (setup) begin
      s_d.prdata = 32'h0000_0000;
      case (paddr)
        sbmc_pkg::MISC_OFFSET:       s_d.prdata = s_q.misc;
        sbmc_pkg::IRQ_STATUS_OFFSET: s_d.prdata = 32'(s_q.irq_status);
        sbmc_pkg::IRQ_MASK_OFFSET:   s_d.prdata = 32'(s_q.irq_mask);
        default:                     s_d.pslverr = 1'b1;
      endcase
    end
    // Writes land on the access edge; an unmapped address changes nothing
    if (wr_acc && !s_q.pslverr) begin
      case (paddr)
        sbmc_pkg::MISC_OFFSET: begin
          // Read-only and reserved bits keep their reset value
          s_d.misc = (s_q.misc & ~sbmc_pkg::MISC_WRITE_MASK)
                   | (pwdata & sbmc_pkg::MISC_WRITE_MASK);
        end
        sbmc_pkg::IRQ_STATUS_OFFSET: begin
          s_d.irq_status = s_q.irq_status & ~pwdata[IRQ_EVT_W-1:0];
        end
        sbmc_pkg::IRQ_MASK_OFFSET: begin
          s_d.irq_mask = pwdata[IRQ_EVT_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Arbiter: high group always wins, round-robin inside a group
    // No preemption: a high request waits until the owner lets go, which
    // keeps a bus tenure whole at the cost of some latency
    eligible = {internal_request, ~s_q.req_sync} & arb_enable;
    high_req = eligible & arb_high;
    pool     = (|high_req) ? high_req : eligible;
    win      = sbmc_rr_pick(pool, s_q.last);
    case (s_q.arb)
      sbmc_pkg::SBMC_ARB_IDLE: begin
        if (|pool) begin
          s_d.grant_n = ~(5'h01 << win);
          s_d.last    = win;
          s_d.arb     = sbmc_pkg::SBMC_ARB_BUSY;
        end
      end
      sbmc_pkg::SBMC_ARB_BUSY: begin
        // Owner keeps the bus until it drops or is disabled
        // A disabled owner loses the grant at once
        if (!eligible[s_q.last]) begin
          s_d.grant_n = 5'h1F;
          s_d.arb     = sbmc_pkg::SBMC_ARB_IDLE;
        end
      end
      default: begin
        s_d.grant_n = 5'h1F;
        s_d.arb     = sbmc_pkg::SBMC_ARB_IDLE;
      end
    endcase

    // Non-posted write parity error handling
    // The behaviour bit is fixed high, so the forward path stays idle
    // unless the bit is ever made writable
    s_d.perr_n     = !np_write_parity_error;
    s_d.np_forward = np_write_parity_error && !perr_discard;
    s_d.np_discard = np_write_parity_error && perr_discard;

    // Completion accumulation before data return
    // A new start restarts the count even if a release is still due
    s_d.acc_release = 1'b0;
    if (cpl_start) begin
      s_d.acc_active = 1'b1;
      s_d.acc_count  = 7'h00;
    end else if (s_q.acc_active) begin
      if (cpl_dword) begin
        s_d.acc_count = s_q.acc_count + 7'h01;
      end
      // A short completion is released by its last dword
      if ((cpl_dword && (s_q.acc_count + 7'h01 >= acc_threshold)) || cpl_last) begin
        s_d.acc_release = 1'b1;
        s_d.acc_active  = 1'b0;
      end
    end

    // Configuration retry timer
    // The code is sampled at the start; a later write affects the next request
    // A completion in the expiry cycle wins and no retry status is sent
    s_d.rt_crs = 1'b0;
    if (cfg1_start) begin
      s_d.rt_active = 1'b1;
      s_d.rt_count  = sbmc_rt_limit(s_q.misc[sbmc_pkg::RT_LSB +: 3]);
    end else if (s_q.rt_active) begin
      if (cfg1_done) begin
        s_d.rt_active = 1'b0;
      end else if (s_q.rt_count == '0) begin
        s_d.rt_crs    = 1'b1;
        s_d.rt_active = 1'b0;
      end else begin
        s_d.rt_count = s_q.rt_count - sbmc_pkg::RT_CNT_W'(1);
      end
    end

    // Sticky events; a set in the clearing cycle wins
    // The interrupt follows the next status and mask, so it moves with them
    irq_set = '0;
    irq_set[sbmc_pkg::IRQ_PERR]      = np_write_parity_error;
    irq_set[sbmc_pkg::IRQ_CFG_RETRY] = s_d.rt_crs;
    irq_set[sbmc_pkg::IRQ_ACC_DONE]  = s_d.acc_release;
    s_d.irq_status = s_d.irq_status | irq_set;
    s_d.irq        = |(s_d.irq_status & s_d.irq_mask);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Request synchroniser resets to idle-high so no false request follows reset
  // Grants and the parity flag reset to their inactive high level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q            <= '0;
      s_q.misc       <= sbmc_pkg::MISC_RESET;
      s_q.req_meta   <= 4'hF;
      s_q.req_sync   <= 4'hF;
      s_q.arb        <= sbmc_pkg::SBMC_ARB_IDLE;
      s_q.grant_n    <= 5'h1F;
      s_q.perr_n     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs, all straight from state flops
  // ****************************************************************
  // Plain wires from flops keep every output glitch free
  // Bus answer
  assign prdata                  = s_q.prdata;
  assign pready                  = s_q.pready;
  assign pslverr                 = s_q.pslverr;
  assign irq                     = s_q.irq;
  // Arbiter grants, active low
  assign secondary_grant_line_n  = s_q.grant_n[3:0];
  assign internal_grant_n        = s_q.grant_n[4];
  // Parity error and control outputs
  assign parity_error_out_n      = s_q.perr_n;
  assign np_write_forward        = s_q.np_forward;
  assign np_write_discard        = s_q.np_discard;
  assign short_term_cache_enable = s_q.misc[sbmc_pkg::SHORT_TERM_CACHE_ENABLE_BIT];
  // Completion and retry events
  assign cpl_release             = s_q.acc_release;
  assign cfg_retry_status        = s_q.rt_crs;

endmodule : sbmc_top

// ---- sbmc_props.sv ----
/* Port checker for sbmc_top.
   Assumes one pclk domain, reset by presetn, bound into every instance. */
`timescale 1ns/1ps
module sbmc_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [3:0]  secondary_grant_line_n,
  input wire logic        internal_grant_n,
  input wire logic        np_write_parity_error,
  input wire logic        parity_error_out_n,
  input wire logic        np_write_forward,
  input wire logic        np_write_discard,
  input wire logic        short_term_cache_enable,
  input wire logic        cpl_start,
  input wire logic        cpl_last,
  input wire logic        cpl_release,
  input wire logic        cfg1_start,
  input wire logic        cfg_retry_status
);
  // ****************
  // Port relations
  // ****************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Control read: reserved clear, behaviour bit fixed high
  rd_reserved_a: assert property (
    psel && !penable && !pwrite && paddr == sbmc_pkg::MISC_OFFSET
    |=> pready && (prdata & 32'h8260_80FF) == 32'h0 && prdata[24]) else $error("reserved or fixed bit wrong");
  perr_pulse_a: assert property (
    np_write_parity_error |=> !parity_error_out_n && np_write_discard) else $error("parity error not handled");
  perr_idle_a: assert property (
    !np_write_parity_error |=> parity_error_out_n && !np_write_discard) else $error("stray parity flag");
  no_forward_a: assert property (
    !np_write_forward) else $error("corrupt data forwarded");
  // Two edges, one more than the write into the control register needs
  cache_bit_a: assert property (
    psel && penable && pready && pwrite && paddr == sbmc_pkg::MISC_OFFSET
    |=> ##1 short_term_cache_enable == $past(pwdata[23], 2)) else $error("cache enable wrong");
  grant_single_a: assert property (
    $onehot0(~{internal_grant_n, secondary_grant_line_n})) else $error("two grants at once");
  cpl_last_a: assert property (
    cpl_last && !cpl_start |=> cpl_release) else $error("last data not released");
  cpl_start_a: assert property (
    cpl_start && !cpl_last |=> !cpl_release) else $error("release before threshold");
  retry_min_a: assert property (
    cfg1_start |-> ##1 !cfg_retry_status [*8]) else $error("retry timer too short");
  retry_pulse_a: assert property (
    cfg_retry_status |=> !cfg_retry_status) else $error("retry status too long");
  // Main scenarios reached
  cover property (cfg_retry_status);
  cover property (cpl_release);
  cover property (!internal_grant_n);
endmodule : sbmc_props
bind sbmc_top sbmc_props u_sbmc_props (.*);

// ---- sbmc_partner.sv ----
/* Model of the external masters on the secondary bus.
   Assumes active-low request and grant lines timed by pclk. */
`timescale 1ns/1ps
module sbmc_partner (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [3:0] want,
  input wire logic [3:0] grant_n,
  output logic     [3:0] req_n
);
  logic [3:0] done_q;
  // A master drops its request the cycle after it sees a grant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 4'h0;
    end else begin
      done_q <= want & (done_q | ~grant_n);
    end
  end
  // Idle lines rest at the pull-up level
  assign req_n = ~(want & ~done_q);
endmodule : sbmc_partner

// ---- sbmc_tb.sv ----
/* Directed testbench for sbmc_top over APB.
   Assumes sbmc_props is bound in and sbmc_partner plays the masters. */
`timescale 1ns/1ps
module tb;
  localparam int          L4  = 50;
  localparam int          L6  = 60;
  localparam int          L7  = 70;
  localparam logic [11:0] CTL = sbmc_pkg::MISC_OFFSET;
  localparam logic [11:0] STS = sbmc_pkg::IRQ_STATUS_OFFSET;
  localparam logic [11:0] MSK = sbmc_pkg::IRQ_MASK_OFFSET;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, irq, erv, igrant_n, perr_n, fwd, disc, stc, crel, rstat;
  logic [3:0]  req_n, grant_n;
  logic [3:0]  want = 4'h0;
  logic        ireq = 1'b0;
  logic        perr = 1'b0;
  logic        cstart = 1'b0;
  logic        cdw = 1'b0;
  logic        clast = 1'b0;
  logic        rstart = 1'b0;
  logic        rdone = 1'b0;
  int          miscompares = 0;
  int          check_count = 0;
  int          n;
  // Long retry counts shortened so the run stays brief
  int          lim [8] = '{625, 1000, 1250, 2500, L4, L6, L6, L7};
  int          codes [5] = '{0, 3, 9, 10, 15};
  always #20 pclk = ~pclk;
  sbmc_top #(.RT4_CYCLES(L4), .RT6_CYCLES(L6), .RT7_CYCLES(L7)) u_sbmc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .secondary_request_line_n(req_n), .internal_request(ireq), .secondary_grant_line_n(grant_n),
    .internal_grant_n(igrant_n), .np_write_parity_error(perr), .parity_error_out_n(perr_n),
    .np_write_forward(fwd), .np_write_discard(disc), .short_term_cache_enable(stc),
    .cpl_start(cstart), .cpl_dword(cdw), .cpl_last(clast), .cpl_release(crel),
    .cfg1_start(rstart), .cfg1_done(rdone), .cfg_retry_status(rstat));
  sbmc_partner u_sbmc_partner (.pclk(pclk), .presetn(presetn), .want(want), .grant_n(grant_n), .req_n(req_n));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge pclk);
    end
    if (k == 50) chk(pready, 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask : rd
  task automatic settle();
    @(posedge pclk);
    #1;
  endtask : settle
  // Requests raised while disabled, then released together
  task automatic arb(input logic [31:0] ctl, input logic [3:0] w, input logic ir, input logic [4:0] e);
    int k = 0;
    apb(1'b1, CTL, 32'h0100_1900);
    @(posedge pclk) want <= w;
    ireq <= ir;
    repeat (6) @(posedge pclk);
    chk({igrant_n, grant_n}, 5'h1F);
    apb(1'b1, CTL, ctl);
    while ({igrant_n, grant_n} === 5'h1F && k < 20) begin
      k++;
      @(posedge pclk);
    end
    chk({igrant_n, grant_n}, e);
    want <= 4'h0;
    ireq <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : arb
  task automatic conclude();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTL, sbmc_pkg::MISC_RESET);
    chk(stc, 1'b0);
    apb(1'b1, CTL, 32'hFFFF_FFFF);
    settle();
    chk(stc, 1'b1);
    rd(CTL, 32'h7D9F_7F00);
    apb(1'b1, CTL, 32'h0);
    rd(CTL, 32'h0100_0000);
    rd(12'h100, 32'h0);
    chk(erv, 1'b1);
    @(posedge pclk) perr <= 1'b1;
    @(posedge pclk) perr <= 1'b0;
    #1 chk({perr_n, disc, fwd}, 3'b010);
    rd(STS, 32'h1);
    apb(1'b1, MSK, 32'h1);
    settle();
    chk(irq, 1'b1);
    apb(1'b1, STS, 32'h1);
    settle();
    chk(irq, 1'b0);
    arb(32'h7D02_1900, 4'h3, 1'b1, 5'b11101);
    arb(32'h7D10_1900, 4'hF, 1'b1, 5'b01111);
    arb(32'h1000_1900, 4'h5, 1'b1, 5'b11011);
    // Threshold is eight dwords per code step, capped at eighty
    for (int c = 0; c < 5; c++) begin
      n = codes[c] > 9 ? 80 : 8 * (codes[c] + 1);
      apb(1'b1, CTL, 32'h7D10_0100 | (32'(codes[c]) << 11));
      @(posedge pclk) cstart <= 1'b1;
      @(posedge pclk) cstart <= 1'b0;
      for (int i = 1; i <= n; i++) begin
        @(posedge pclk) cdw <= 1'b1;
        @(posedge pclk) cdw <= 1'b0;
        #1 chk(crel, i == n);
      end
    end
    @(posedge pclk) cstart <= 1'b1;
    @(posedge pclk) cstart <= 1'b0;
    @(posedge pclk) clast <= 1'b1;
    @(posedge pclk) clast <= 1'b0;
    #1 chk(crel, 1'b1);
    // Every timer code; expiry shows exactly limit edges after the start is seen
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, CTL, 32'h7D10_1800 | (32'(c) << 8));
      @(posedge pclk) rstart <= 1'b1;
      @(posedge pclk) rstart <= 1'b0;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
        #1;
      end while (rstat !== 1'b1 && n < lim[c] + 5);
      chk(n, lim[c]);
    end
    apb(1'b1, CTL, 32'h7D10_1C00);
    @(posedge pclk) rstart <= 1'b1;
    @(posedge pclk) rstart <= 1'b0;
    repeat (10) @(posedge pclk);
    rdone <= 1'b1;
    @(posedge pclk) rdone <= 1'b0;
    n = 0;
    repeat (L4 + 10) begin
      @(posedge pclk);
      if (rstat !== 1'b0) n++;
    end
    chk(n, 0);
    rd(STS, 32'h6);
    apb(1'b1, MSK, 32'h6);
    settle();
    chk(irq, 1'b1);
    conclude();
  end
  // Whole sequence needs under ten thousand cycles
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    conclude();
  end
endmodule : tb
